// ---- logic/pecl_consts.svh ----
// Constants for the link event counter log page builder
`ifndef PECL_CONSTS_SVH
`define PECL_CONSTS_SVH
`define PECL_PAGE_BYTES    10'd512
`define PECL_LAST_BYTE     9'h1ff
`define PECL_HDR_BYTES     9'h004
`define PECL_ID_SIG        12'h00a
`define PECL_ID_CRC        12'h00b
`define PECL_ID_NONCRC     12'h00d
`define PECL_ID_END        16'h0000
`define PECL_SIZE_LSB      12
`define PECL_SIZE_16       3'h1
`define PECL_SIZE_32       3'h2
`define PECL_SIZE_48       3'h3
`define PECL_SIZE_64       3'h4
`define PECL_VENDOR_BIT    15
`define PECL_ENTRY_BYTES   9'h004
`define PECL_NUM_ENTRIES   3
`define PECL_FIFO_DEPTH    8
`endif

// ---- logic/pecl_pkg.sv ----
// Types shared by the log page builder and its helpers
package pecl_pkg;
  // Link events, each a one-cycle pulse
  typedef struct packed {
    logic sig_ack;
    logic crc_err;
    logic other_err;
    logic bist;
  } pecl_evt_t;
  // Page read request
  typedef struct packed {
    logic start;
    logic clear_after;
  } pecl_req_t;
  // Page byte with its position
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } pecl_byte_t;
  typedef enum logic [2:0] {
    PECL_IDLE = 3'b001,
    PECL_SEND = 3'b010,
    PECL_SUM  = 3'b100
  } pecl_state_t;
endpackage : pecl_pkg

// ---- logic/pecl_sat_counter.sv ----
// Saturating event counter, extended to the reported width with its full flag (ones only when saturated)
module pecl_sat_counter #(
  parameter int PHYS_W = 8,
  parameter int REP_W  = 16
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             event_in,
  input  wire logic             clear_in,
  output logic [REP_W-1:0]      value_out
);
  logic [PHYS_W-1:0] count_q;
  logic [PHYS_W-1:0] count_d;
  logic              full;

  // Holds at maximum, never wraps; clear wins since the event is then forgotten by design
  always_comb
  begin
    full    = &count_q;
    count_d = count_q;
    if (clear_in)
      count_d = '0;
    else if (event_in && !full) // R10
      count_d = count_q + PHYS_W'(1);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  // Upper bits follow saturation so a full counter reads all ones
  assign value_out = {{(REP_W-PHYS_W){full}}, count_q}; // R9
endmodule : pecl_sat_counter

// ---- logic/pecl_fifo.sv ----
// Small valid/ready FIFO for the outgoing page bytes
module pecl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Pointer and fill count update
  always_comb
  begin
    push  = in_valid_in && (cnt_q != (AW+1)'(DEPTH));
    pop   = out_ready_in && (cnt_q != '0);
    wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1)) : wr_q;
    rd_d  = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1)) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
endmodule : pecl_fifo

// ---- logic/pecl_log_page.sv ----
// Link event counters and the 512-byte counter log page they are read through
// Notes on behaviour
// R1: Count acknowledged reset-signature Register frames, id 00Ah
// R2: Count frames refused for CRC, id 00Bh
// R3: Count frames refused for other causes, id 00Dh
// R4: Page is exactly 512 bytes
// R5: Header, tail and reserved bytes are zero
// R6: Zero identifier ends the entry list
// R7: Each entry starts with 16-bit identifier
// R8: Value width comes from identifier bits 14:12
// R9: Saturated narrow counters read as all ones
// R10: Counters saturate and hold
// R11: Last byte makes page sum zero
// R12: Host parses until zero identifier or page end
// R13: Size codes 1..4 mean 16..64 bits
// R14: BIST activation clears all counters
// R15: Read with clear flag returns then clears
// R16: Bit 15 marks vendor counters, size still coded
// R17: Entries packed from byte 4, low byte first
`include "pecl_consts.svh"

// A start pulse snapshots the counters; the page then streams out through
// the byte FIFO, one byte per accepted transfer, with last on the checksum
module pecl_log_page #(
  parameter int PHYS_W = 8
) (
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  input  wire pecl_pkg::pecl_evt_t evt_in,
  input  wire pecl_pkg::pecl_req_t req_in,
  output logic                     busy_out,
  output pecl_pkg::pecl_byte_t     page_byte_out,
  output logic                     page_valid_out,
  input  wire logic                page_ready_in
);
  import pecl_pkg::*;

  // Every counter is reported in one 16-bit field
  localparam int REP_W = 16;

  // Counter values as reported, and the clear strobe shared by all counters
  logic [REP_W-1:0] val_sig, val_crc, val_oth;
  logic             clr_cnt;

  // Sequencer position in the page
  pecl_state_t      state_q, state_d;
  logic [8:0]       idx_q, idx_d;

  // Read context: running sum, pending clear and the counter snapshot
  logic [7:0]       sum_q, sum_d;
  logic             clr_pend_q, clr_pend_d;
  logic [REP_W-1:0] snap_q [`PECL_NUM_ENTRIES];
  logic [REP_W-1:0] snap_d [`PECL_NUM_ENTRIES];

  // Byte FIFO write and read sides
  logic             f_ready, f_valid;
  pecl_byte_t       f_in, f_out;
  logic             emit;
  logic [7:0]       cur_byte;

  // Output stage
  pecl_byte_t       out_q, out_d;
  logic             ov_q, ov_d;
  logic             busy_q, busy_d;

  // Builds an identifier with its size code; vendor bit left clear
  function automatic logic [15:0] make_id(input logic [11:0] code);
    logic [15:0] id;
    id = 16'h0000;
    id[`PECL_VENDOR_BIT] = 1'b0; // R16
    id[`PECL_SIZE_LSB +: 3] = `PECL_SIZE_16; // R8 R13
    id[11:0] = code;
    return id;
  endfunction : make_id

  // Page byte map, one row per region
  //   0..3     header, zero
  //   4..7     entry for acknowledged reset signatures
  //   8..11    entry for CRC refusals
  //   12..15   entry for other refusals
  //   16..17   end identifier, zero
  //   18..510  reserved, zero
  //   511      checksum
  // Each entry is id low, id high, value low, value high
  // Picks the page byte at a given position from the snapshot
  function automatic logic [7:0] page_byte(input logic [8:0] pos,
                                           input logic [REP_W-1:0] s0,
                                           input logic [REP_W-1:0] s1,
                                           input logic [REP_W-1:0] s2);
    logic [8:0]  rel;
    logic [1:0]  ent;
    logic [1:0]  off;
    logic [15:0] id;
    logic [15:0] val;
    // Position relative to the first entry; wraps high inside the header
    rel = pos - `PECL_HDR_BYTES;
    ent = rel[3:2];
    off = rel[1:0];
    id  = `PECL_ID_END;
    val = 16'h0000;
    page_byte = 8'h00; // R5
    if (pos >= `PECL_HDR_BYTES && rel < 9'(`PECL_NUM_ENTRIES * 4)) // R17
    begin
      // Identifier and snapshot value of the entry
      case (ent)
        2'd0:
        begin
          id  = make_id(`PECL_ID_SIG);
          val = s0;
        end
        2'd1:
        begin
          id  = make_id(`PECL_ID_CRC);
          val = s1;
        end
        default:
        begin
          id  = make_id(`PECL_ID_NONCRC);
          val = s2;
        end
      endcase
      // Identifier before value, low byte first in each
      case (off) // R7 R17
        2'd0:    page_byte = id[7:0];
        2'd1:    page_byte = id[15:8];
        2'd2:    page_byte = val[7:0];
        default: page_byte = val[15:8];
      endcase
    end
    // The two bytes after the last entry form the zero end identifier
    if (rel == 9'(`PECL_NUM_ENTRIES * 4) || rel == 9'(`PECL_NUM_ENTRIES * 4 + 1))
      page_byte = 8'h00; // R6
  endfunction : page_byte

  // Counters clear on BIST activation or when a clearing read queues its checksum
  // An event in the clearing cycle is lost; the page already holds the snapshot
  assign clr_cnt = evt_in.bist // R14
                 || (state_q == PECL_SUM && emit && clr_pend_q); // R15

  // One saturating counter per reported event
  pecl_sat_counter #(.PHYS_W(PHYS_W), .REP_W(REP_W)) u_cnt_sig (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .event_in   (evt_in.sig_ack), // R1
    .clear_in   (clr_cnt),
    .value_out  (val_sig)
  );

  pecl_sat_counter #(.PHYS_W(PHYS_W), .REP_W(REP_W)) u_cnt_crc (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .event_in   (evt_in.crc_err), // R2
    .clear_in   (clr_cnt),
    .value_out  (val_crc)
  );

  pecl_sat_counter #(.PHYS_W(PHYS_W), .REP_W(REP_W)) u_cnt_oth (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .event_in   (evt_in.other_err), // R3
    .clear_in   (clr_cnt),
    .value_out  (val_oth)
  );

  // Byte offered to the FIFO: page body from the snapshot, then the checksum
  always_comb
  begin
    cur_byte  = page_byte(idx_q, snap_q[0], snap_q[1], snap_q[2]);
    emit      = f_ready && (state_q == PECL_SEND || state_q == PECL_SUM);
    f_in.data = cur_byte;
    f_in.last = 1'b0;
    if (state_q == PECL_SUM)
    begin
      f_in.data = 8'h00 - sum_q; // R11
      f_in.last = 1'b1; // R4
    end
  end

  // Page sequencer: waits for a request, streams 511 bytes, then the checksum
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    case (state_q)
      PECL_IDLE:
      begin
        if (req_in.start)
        begin
          idx_d   = 9'h000;
          state_d = PECL_SEND;
        end
      end
      PECL_SEND:
      begin
        if (emit)
        begin
          idx_d = idx_q + 9'h001;
          if (idx_q == `PECL_LAST_BYTE - 9'h001)
            state_d = PECL_SUM;
        end
      end
      PECL_SUM:
      begin
        if (emit)
          state_d = PECL_IDLE;
      end
      default:
        state_d = PECL_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= PECL_IDLE;
      idx_q   <= 9'h000;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // Read context: snapshot and clear flag at the start, running sum per body byte
  always_comb
  begin
    snap_d     = snap_q;
    clr_pend_d = clr_pend_q;
    sum_d      = sum_q;
    if (state_q == PECL_IDLE && req_in.start)
    begin
      snap_d[0]  = val_sig;
      snap_d[1]  = val_crc;
      snap_d[2]  = val_oth;
      clr_pend_d = req_in.clear_after; // R15
      sum_d      = 8'h00;
    end
    else if (state_q == PECL_SEND && emit)
      sum_d = sum_q + cur_byte; // R11
  end

  // Read context registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      sum_q      <= 8'h00;
      clr_pend_q <= 1'b0;
      snap_q     <= '{default: '0};
    end
    else
    begin
      sum_q      <= sum_d;
      clr_pend_q <= clr_pend_d;
      snap_q     <= snap_d;
    end
  end

  // Eight-byte FIFO decouples the sequencer from reader stalls
  // The sequencer only advances on bytes the FIFO accepts
  pecl_fifo #(.WIDTH($bits(pecl_byte_t)), .DEPTH(`PECL_FIFO_DEPTH)) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (emit),
    .in_ready_out  (f_ready),
    .in_data_in    (f_in),
    .out_valid_out (f_valid),
    .out_ready_in  (!ov_q || page_ready_in),
    .out_data_out  (f_out)
  );

  // Registered output stage so every output comes from a flip-flop
  // A new byte loads when the stage is empty or its byte is taken
  always_comb
  begin
    out_d  = out_q;
    ov_d   = ov_q;
    busy_d = (state_d != PECL_IDLE); // Busy until the checksum is queued
    if (!ov_q || page_ready_in)
    begin
      ov_d  = f_valid;
      out_d = f_valid ? f_out : '0;
    end
  end

  // Output registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      out_q  <= '0;
      ov_q   <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      out_q  <= out_d;
      ov_q   <= ov_d;
      busy_q <= busy_d;
    end
  end

  assign page_byte_out  = out_q;
  assign page_valid_out = ov_q;
  assign busy_out       = busy_q;
endmodule : pecl_log_page

// ---- verif/pecl_log_page_props.sv ----
// Checker on the page byte stream of the log page builder
module pecl_log_page_props (
  input wire logic                 ref_clk_in,
  input wire logic                 reset_n_in,
  input wire pecl_pkg::pecl_evt_t  evt_in,
  input wire pecl_pkg::pecl_req_t  req_in,
  input wire logic                 busy_out,
  input wire pecl_pkg::pecl_byte_t page_byte_out,
  input wire logic                 page_valid_out,
  input wire logic                 page_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pecl_pkg::*;
  logic       v;
  logic       l;
  logic [7:0] d;
  logic [8:0] pos_q;
  logic [7:0] sum_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Short names for the stream fields
  assign v = page_valid_out;
  assign l = page_byte_out.last;
  assign d = page_byte_out.data;
  // Position and running sum of accepted bytes
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in || (v && page_ready_in && l))
    begin
      pos_q <= '0;
      sum_q <= '0;
    end
    else if (v && page_ready_in)
    begin
      pos_q <= pos_q + 9'h001;
      sum_q <= sum_q + d;
    end
  end
  property p_hold;
    v && !page_ready_in |=> v && $stable(page_byte_out);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost in stall");
  property p_start;
    req_in.start && !busy_out && !v |=> busy_out;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_last;
    v |-> l == (pos_q == 9'h1ff);
  endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
  property p_head;
    v && pos_q < 9'h004 |-> d == 8'h00;
  endproperty
  a_head: assert property (p_head) else $error("header not zero");
  property p_size;
    v && pos_q inside {9'h005, 9'h009, 9'h00d} |-> d == 8'h10;
  endproperty
  a_size: assert property (p_size) else $error("size code wrong");
  property p_end;
    v && pos_q inside {9'h010, 9'h011} |-> d == 8'h00;
  endproperty
  a_end: assert property (p_end) else $error("end id not zero");
  property p_tail;
    v && pos_q > 9'h011 && !l |-> d == 8'h00;
  endproperty
  a_tail: assert property (p_tail) else $error("tail not zero");
  property p_sum;
    v && l |-> 8'(sum_q + d) == 8'h00;
  endproperty
  a_sum: assert property (p_sum) else $error("checksum wrong");
endmodule : pecl_log_page_props
bind pecl_log_page pecl_log_page_props u_props (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .evt_in(evt_in), .req_in(req_in), .busy_out(busy_out), .page_byte_out(page_byte_out),
  .page_valid_out(page_valid_out), .page_ready_in(page_ready_in));

// ---- verif/pecl_host_model.sv ----
// Host reader model that drains page bytes, promptly or with stalls
module pecl_host_model (
  input  wire logic                 ref_clk_in,
  input  wire logic                 slow_in,
  input  wire pecl_pkg::pecl_byte_t byte_in,
  input  wire logic                 valid_in,
  output logic                      ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [512];
  int         n = 0;
  initial ready_out = 1'b1;
  // Store each accepted byte, then move ready just after the edge
  always @(posedge ref_clk_in)
  begin
    if (valid_in && ready_out)
    begin
      mem[n % 512] = byte_in.data;
      n = n + 1;
    end
    ready_out <= #1 slow_in ? ~ready_out : 1'b1;
  end
endmodule : pecl_host_model

// ---- verif/pecl_log_page_tb.sv ----
// Bench for the link event counter log page builder
module pecl_log_page_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pecl_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       slow = 1'b0;
  pecl_evt_t  evt_in = '0;
  pecl_req_t  req_in = '0;
  logic       busy_out;
  logic       page_valid_out;
  logic       page_ready_in;
  pecl_byte_t page_byte_out;
  int         errors = 0;
  int         tests_run = 0;
  int         cycles = 0;
  // Clock of 5 ns
  always #2.5 ref_clk_in = ~ref_clk_in;
  pecl_log_page #(.PHYS_W(8)) uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .evt_in(evt_in),
    .req_in(req_in), .busy_out(busy_out), .page_byte_out(page_byte_out),
    .page_valid_out(page_valid_out), .page_ready_in(page_ready_in));
  pecl_host_model host (.ref_clk_in(ref_clk_in), .slow_in(slow), .byte_in(page_byte_out),
    .valid_in(page_valid_out), .ready_out(page_ready_in));
  task end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Cut a hang short
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end
  // Pulse event k a number of times, one idle cycle between
  task pulse(input int k, input int cnt);
    repeat (cnt)
    begin
      evt_in = 4'h8 >> k;
      @(posedge ref_clk_in);
      #1 evt_in = '0;
      @(posedge ref_clk_in);
      #1;
    end
  endtask : pulse
  // Read one page and compare it with the expected counter values
  task automatic read_page(input logic clr, input logic [15:0] a, b, c);
    int         base;
    int         k;
    int         pos;
    int         ents;
    logic [7:0] e [512];
    logic [7:0] s;
    base = host.n;
    req_in = {1'b1, clr};
    @(posedge ref_clk_in);
    #1 req_in = '0;
    tests_run++;
    if (busy_out !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t start not taken", $time);
    end
    for (k = 0; k < 3000 && host.n < base + 512; k++)
      @(posedge ref_clk_in);
    #1;
    tests_run++;
    if (host.n != base + 512 || busy_out !== 1'b0)
    begin
      errors++;
      $display("[ERR] %0t page incomplete, %0d bytes", $time, host.n - base);
    end
    e = '{default: 8'h00};
    {e[5], e[4], e[7], e[6]} = {16'h100a, a};
    {e[9], e[8], e[11], e[10]} = {16'h100b, b};
    {e[13], e[12], e[15], e[14]} = {16'h100d, c};
    s = 8'h00;
    for (k = 0; k < 511; k++)
      s += e[k];
    e[511] = -s;
    for (k = 0; k < 512; k++)
    begin
      tests_run++;
      if (host.mem[k] !== e[k])
      begin
        errors++;
        $display("[ERR] %0t byte %0d got %h exp %h", $time, k, host.mem[k], e[k]);
      end
    end
    // Walk the entries as a host would, until a zero identifier; three are expected
    pos  = 4;
    ents = 0;
    while (pos < 510 && {host.mem[pos + 1], host.mem[pos]} !== 16'h0000)
    begin
      pos += 2 + 2 * int'(host.mem[pos + 1][6:4]);
      ents++;
    end
    tests_run++;
    if (ents != 3)
    begin
      errors++;
      $display("[ERR] %0t parsed %0d entries", $time, ents);
    end
  endtask : read_page
  // Plain counts for each event kind
  task t_counts;
    pulse(0, 3);
    pulse(1, 5);
    pulse(2, 7);
    read_page(1'b0, 16'h0003, 16'h0005, 16'h0007);
  endtask : t_counts
  // Same page again with the reader stalling every other cycle
  task t_stall;
    slow = 1'b1;
    read_page(1'b0, 16'h0003, 16'h0005, 16'h0007);
    slow = 1'b0;
  endtask : t_stall
  // Read with clear, then the counters read zero
  task t_clear;
    read_page(1'b1, 16'h0003, 16'h0005, 16'h0007);
    read_page(1'b0, 16'h0000, 16'h0000, 16'h0000);
  endtask : t_clear
  // Saturation against one below the maximum
  task t_sat;
    pulse(0, 300);
    pulse(1, 254);
    pulse(2, 1);
    read_page(1'b0, 16'hffff, 16'h00fe, 16'h0001);
  endtask : t_sat
  // Test activation clears every counter
  task t_bist;
    pulse(3, 1);
    read_page(1'b0, 16'h0000, 16'h0000, 16'h0000);
  endtask : t_bist
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    t_counts();
    t_stall();
    t_clear();
    t_sat();
    t_bist();
    end_of_test();
  end
endmodule : pecl_log_page_tb
